// File: src/uss_shadow_port.sv
// Shadow receive/transmit data port with FIFOs, status and interrupt
//
// Local design decision: the address-and-strobe port.
module uss_shadow_port
  import uss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata_r,
  input wire logic rx_ser_valid,
  input wire logic [BYTE_W-1:0] rx_ser_byte,
  input wire logic rx_ir_valid,
  input wire logic [BYTE_W-1:0] rx_ir_byte,
  input wire logic tx_ser_ready,
  input wire logic tx_ir_ready,
  output logic tx_ser_valid_r,
  output logic tx_ir_valid_r,
  output logic [BYTE_W-1:0] tx_data_r,
  output logic irq_r
);
  // Shadow alias window: any aligned word in the sixteen locations
  function automatic logic in_shadow(input logic [ADDR_W-1:0] a);
    return (a >= SHD_BASE) && (a <= SHD_LAST) && (a[1:0] == WORD_ALIGN);
  endfunction

  // Full test shared by both FIFOs
  function automatic logic cnt_full(input logic [CNT_W-1:0] c);
    return c == CNT_FULL;
  endfunction

  logic fifo_en_r; // FIFO enable control bit
  logic ir_mode_r; // Infrared path select
  logic [CNT_W-1:0] rx_cnt_r; // Receive fill (0 or 1 with FIFO off)
  logic [CNT_W-1:0] tx_cnt_r; // Transmit fill (0 or 1 with FIFO off)
  logic [PTR_W-1:0] rx_wp_r; // Receive write pointer
  logic [PTR_W-1:0] rx_rp_r; // Receive read pointer
  logic [PTR_W-1:0] tx_wp_r; // Transmit write pointer
  logic [PTR_W-1:0] tx_rp_r; // Transmit read pointer
  logic [BYTE_W-1:0] rx_hold_r; // Receive buffer when FIFO off
  logic [BYTE_W-1:0] tx_hold_r; // Transmit holding when FIFO off
  logic [EV_W-1:0] istat_r; // Sticky interrupt status
  logic [EV_W-1:0] imask_r; // Interrupt mask
  logic tx_holding_empty_flag_d_r; // Holding-empty seen last cycle

  uss_mem_if rx_m (); // Receive FIFO storage port
  uss_mem_if tx_m (); // Transmit FIFO storage port

  uss_mem u_rx_mem (.clk_sys(clk_sys), .rstn(rstn), .m(rx_m));
  uss_mem u_tx_mem (.clk_sys(clk_sys), .rstn(rstn), .m(tx_m));

  // Address decode
  wire sel_shd = in_shadow(addr);
  wire sel_ctrl = addr == CTRL_ADDR;
  wire sel_stat = addr == STAT_ADDR;
  wire sel_istat = addr == ISTAT_ADDR;
  wire sel_imask = addr == IMASK_ADDR;
  wire shd_rd = rd & sel_shd;
  wire shd_wr = wr & sel_shd;

  // Changing the FIFO enable empties both paths, as stale slots
  // from the other mode would otherwise be served as data
  wire flush = wr & sel_ctrl & (wdata[CTRL_FIFO_EN] != fifo_en_r);

  // Receive source follows the mode bit
  wire rx_in_valid = ir_mode_r ? rx_ir_valid : rx_ser_valid;
  wire [BYTE_W-1:0] rx_in_byte = ir_mode_r ? rx_ir_byte : rx_ser_byte;

  // Receive bookkeeping
  wire rx_dr = rx_cnt_r != '0; // Data ready
  wire rx_full = cnt_full(rx_cnt_r);
  wire rx_pop = shd_rd & rx_dr;
  // FIFO off always takes the byte; FIFO on only with room or a same-cycle pop
  wire rx_push = rx_in_valid & (~fifo_en_r | ~rx_full | rx_pop);
  wire rx_ovr = rx_in_valid & rx_dr & ~rx_pop
                & (~fifo_en_r | rx_full);
  wire rx_fpush = fifo_en_r & rx_push;
  wire rx_fpop = fifo_en_r & rx_pop;
  wire [PTR_W-1:0] rx_rp_nxt = flush ? '0 : rx_rp_r + PTR_W'(rx_fpop);
  wire [CNT_W-1:0] rx_cnt_nxt = fifo_en_r
    ? rx_cnt_r + CNT_W'(rx_push) - CNT_W'(rx_pop)
    : (rx_in_valid ? CNT_ONE : (rx_pop ? '0 : rx_cnt_r));
  wire [BYTE_W-1:0] rx_head = fifo_en_r ? rx_m.q : rx_hold_r;

  assign rx_m.we = rx_fpush;
  assign rx_m.waddr = rx_wp_r;
  assign rx_m.wdata = rx_in_byte;
  assign rx_m.raddr = rx_rp_nxt;

  // Transmit bookkeeping
  wire tx_dr = tx_cnt_r != '0;
  wire tx_full = cnt_full(tx_cnt_r);
  wire tx_holding_empty_flag = ~tx_dr; // Holding empty flag
  wire tx_vld = tx_ser_valid_r | tx_ir_valid_r;
  wire tx_rdy = ir_mode_r ? tx_ir_ready : tx_ser_ready;
  wire tx_load = tx_dr & (~tx_vld | tx_rdy); // Move head to output
  wire tx_push = shd_wr & (~fifo_en_r | ~tx_full);
  wire tx_fpush = fifo_en_r & tx_push;
  wire tx_fpop = fifo_en_r & tx_load;
  wire [PTR_W-1:0] tx_rp_nxt = flush ? '0 : tx_rp_r + PTR_W'(tx_fpop);
  wire [CNT_W-1:0] tx_cnt_nxt = fifo_en_r
    ? tx_cnt_r + CNT_W'(tx_push) - CNT_W'(tx_load)
    : (shd_wr ? CNT_ONE : (tx_load ? '0 : tx_cnt_r));
  wire [BYTE_W-1:0] tx_head = fifo_en_r ? tx_m.q : tx_hold_r;

  assign tx_m.we = tx_fpush;
  assign tx_m.waddr = tx_wp_r;
  assign tx_m.wdata = wdata[BYTE_W-1:0];
  assign tx_m.raddr = tx_rp_nxt;

  // Events and sticky status; a new event beats a same-cycle clear
  wire [EV_W-1:0] ev;
  assign ev[EV_RX] = rx_push;
  assign ev[EV_OVR] = rx_ovr;
  assign ev[EV_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag & ~tx_holding_empty_flag_d_r;
  wire [EV_W-1:0] iclr = (wr & sel_istat) ? wdata[EV_W-1:0] : '0;
  wire [EV_W-1:0] istat_nxt = (istat_r & ~iclr) | ev;

  // Status word
  wire [DATA_W-1:0] stat_word = (DATA_W'(rx_dr) << STAT_DR)
    | (DATA_W'(rx_full) << STAT_RX_FULL)
    | (DATA_W'(tx_full) << STAT_TX_FULL)
    | (DATA_W'(tx_holding_empty_flag) << STAT_TX_HOLDING_EMPTY_FLAG);

  // Read mux; unmapped addresses read zero, shadow upper bits zero
  wire [DATA_W-1:0] rd_mux = sel_shd ? DATA_W'(rx_head)
    : sel_ctrl ? (DATA_W'(ir_mode_r) << CTRL_IR_MODE)
                 | (DATA_W'(fifo_en_r) << CTRL_FIFO_EN)
    : sel_stat ? stat_word
    : sel_istat ? DATA_W'(istat_r)
    : sel_imask ? DATA_W'(imask_r)
    : '0;

  // Control register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fifo_en_r <= CTRL_RST;
      ir_mode_r <= CTRL_RST;
    end else if (wr && sel_ctrl) begin
      fifo_en_r <= wdata[CTRL_FIFO_EN];
      ir_mode_r <= wdata[CTRL_IR_MODE];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd ? rd_mux : '0;
    end
  end

  // Receive state
  always_ff @(posedge clk_sys) begin
    if (!rstn || flush) begin
      rx_cnt_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end else begin
      rx_cnt_r <= rx_cnt_nxt;
      rx_wp_r <= rx_wp_r + PTR_W'(rx_fpush);
      rx_rp_r <= rx_rp_nxt;
    end
  end

  // Receive buffer for FIFO-off mode overwrites any unread byte
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_hold_r <= '0;
    end else if (!fifo_en_r && rx_in_valid) begin
      rx_hold_r <= rx_in_byte;
    end
  end

  // Transmit state
  always_ff @(posedge clk_sys) begin
    if (!rstn || flush) begin
      tx_cnt_r <= '0;
      tx_wp_r <= '0;
      tx_rp_r <= '0;
    end else begin
      tx_cnt_r <= tx_cnt_nxt;
      tx_wp_r <= tx_wp_r + PTR_W'(tx_fpush);
      tx_rp_r <= tx_rp_nxt;
    end
  end

  // Holding byte for FIFO-off mode; later writes replace it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_hold_r <= '0;
    end else if (!fifo_en_r && shd_wr) begin
      tx_hold_r <= wdata[BYTE_W-1:0];
    end
  end

  // Output stage to the selected transmitter
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tx_ser_valid_r <= 1'b0;
      tx_ir_valid_r <= 1'b0;
      tx_data_r <= '0;
    end else if (tx_load) begin
      tx_ser_valid_r <= ~ir_mode_r;
      tx_ir_valid_r <= ir_mode_r;
      tx_data_r <= tx_head;
    end else if (tx_rdy) begin
      tx_ser_valid_r <= 1'b0;
      tx_ir_valid_r <= 1'b0;
    end
  end

  // Interrupt status, mask and output; the output lags status by one
  // cycle so that it stays a clean flop output
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      istat_r <= EV_RST;
      imask_r <= EV_RST;
      tx_holding_empty_flag_d_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      tx_holding_empty_flag_d_r <= tx_holding_empty_flag;
      irq_r <= |(istat_r & imask_r);
      if (wr && sel_imask) begin
        imask_r <= wdata[EV_W-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_ALIAS_POP: assert property (
    fifo_en_r && shd_rd && rx_dr && !rx_in_valid && !flush
    |=> rx_cnt_r == $past(rx_cnt_r) - CNT_ONE
  ) else $error("shadow read did not pop receive FIFO");

  AST_RX_SRC: assert property (
    !fifo_en_r && ir_mode_r && rx_ir_valid && !flush
    |=> rx_hold_r == $past(rx_ir_byte) && rx_dr
  ) else $error("infrared byte not captured");

  AST_EMPTY_READ: assert property (
    shd_rd && !rx_dr && !rx_in_valid && !flush |=> !rx_dr
  ) else $error("read of empty receive path changed it");

  AST_OVERWRITE: assert property (
    !fifo_en_r && rx_dr && rx_in_valid && !shd_rd && !flush
    |=> istat_r[EV_OVR] && rx_hold_r == $past(rx_in_byte)
  ) else $error("overwrite without overrun");

  AST_HEAD_DATA: assert property (
    shd_rd && fifo_en_r |=> rdata_r[BYTE_W-1:0] == $past(rx_m.q)
  ) else $error("read did not return FIFO head");

  AST_RX_FULL_KEEP: assert property (
    fifo_en_r && rx_full && rx_in_valid && !shd_rd && !flush
    |=> rx_full && $stable(rx_wp_r) && istat_r[EV_OVR]
  ) else $error("full receive FIFO changed or missed overrun");

  AST_TX_OUT: assert property (
    tx_load && ir_mode_r
    |=> tx_ir_valid_r && !tx_ser_valid_r && tx_data_r == $past(tx_head)
  ) else $error("byte not routed to infrared transmitter");

  AST_REPLACE: assert property (
    !fifo_en_r && shd_wr && !flush
    |=> !tx_holding_empty_flag && tx_hold_r == $past(wdata[BYTE_W-1:0])
  ) else $error("holding write did not clear empty or replace");

  AST_TX_ACCEPT: assert property (
    fifo_en_r && shd_wr && !tx_full && !tx_load && !flush
    |=> tx_cnt_r == $past(tx_cnt_r) + CNT_ONE
  ) else $error("transmit FIFO refused write with room");

  AST_TX_DROP: assert property (
    fifo_en_r && shd_wr && tx_full && !tx_load && !flush
    |=> tx_full ##0 $stable(tx_wp_r)
  ) else $error("write into full transmit FIFO was kept");

  AST_RSVD_ZERO: assert property (
    shd_rd |=> rdata_r[DATA_W-1:BYTE_W] == '0
  ) else $error("reserved shadow bits not zero");

  COV_RX_FULL: cover property (fifo_en_r && rx_full && rx_in_valid);
  COV_TX_FULL: cover property (fifo_en_r && tx_full && shd_wr);
  COV_REPLACE: cover property (!fifo_en_r && tx_dr && shd_wr);
  COV_IRQ: cover property ($rose(irq_r));
endmodule

// File: src/uss_pkg.sv
// Package of constants for the shadow receive/transmit data port
package uss_pkg;
  localparam int ADDR_W = 32; // Bus address width
  localparam int DATA_W = 32; // Bus data width
  localparam int BYTE_W = 8; // Character width
  localparam int FIFO_DEPTH = 16; // Receive and transmit FIFO depth
  localparam int PTR_W = 4; // FIFO pointer width
  localparam int CNT_W = 5; // FIFO fill count width
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10; // Fill count when full
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01; // Single held byte

  // Sixteen aliased shadow words, one per 32-bit location
  localparam logic [ADDR_W-1:0] SHD_BASE = 32'h5000_1030;
  localparam logic [ADDR_W-1:0] SHD_LAST = 32'h5000_106C;
  localparam logic [ADDR_W-1:0] SHD_12_ADDR = 32'h5000_1060;
  localparam logic [ADDR_W-1:0] SHD_13_ADDR = 32'h5000_1064;
  localparam logic [1:0] WORD_ALIGN = 2'h0; // Low address bits of a word

  // Control, status and interrupt registers of this port
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 32'h5000_1080;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 32'h5000_1084;
  localparam logic [ADDR_W-1:0] ISTAT_ADDR = 32'h5000_1088;
  localparam logic [ADDR_W-1:0] IMASK_ADDR = 32'h5000_108C;

  // Control bits: FIFO enable and infrared mode
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_IR_MODE = 1;
  localparam logic CTRL_RST = 1'h0;

  // Status bits
  localparam int STAT_DR = 0; // Data ready
  localparam int STAT_RX_FULL = 1; // Receive FIFO full
  localparam int STAT_TX_FULL = 4; // Transmit FIFO full
  localparam int STAT_TX_HOLDING_EMPTY_FLAG = 5; // Transmit holding empty

  // Interrupt event bits
  localparam int EV_RX = 0; // Byte received
  localparam int EV_OVR = 1; // Overrun
  localparam int EV_TX_HOLDING_EMPTY_FLAG = 2; // Transmit holding became empty
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;
endpackage

// File: src/uss_mem_if.sv
// Interface between the port logic and one FIFO storage array
interface uss_mem_if;
  import uss_pkg::*;
  logic we; // Write enable
  logic [PTR_W-1:0] waddr; // Write slot
  logic [BYTE_W-1:0] wdata; // Write byte
  logic [PTR_W-1:0] raddr; // Slot to show next cycle
  logic [BYTE_W-1:0] q; // Registered read byte
  modport mem (input we, input waddr, input wdata, input raddr, output q);
  modport user (output we, output waddr, output wdata, output raddr,
                input q);
endinterface

// File: src/uss_mem.sv
// Sixteen-byte storage with registered read and write-through
module uss_mem
  import uss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  uss_mem_if.mem m
);
  logic [BYTE_W-1:0] arr [FIFO_DEPTH]; // Storage, no reset needed
  logic [BYTE_W-1:0] q_nxt; // Next registered read value

  // Forward a same-slot write so the head never shows a stale byte
  assign q_nxt = (m.we && m.waddr == m.raddr) ? m.wdata : arr[m.raddr];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (m.we) begin
      arr[m.waddr] <= m.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      m.q <= '0;
    end else begin
      m.q <= q_nxt;
    end
  end
endmodule

// File: test/uss_far_end.sv
// Far-end transceiver model: sends received bytes, takes transmitted ones
module uss_far_end
  import uss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic stall, // Holds both transmit readies low
  input wire logic tx_ser_valid_r,
  input wire logic tx_ir_valid_r,
  input wire logic [BYTE_W-1:0] tx_data_r,
  output logic rx_ser_valid,
  output logic [BYTE_W-1:0] rx_ser_byte,
  output logic rx_ir_valid,
  output logic [BYTE_W-1:0] rx_ir_byte,
  output logic tx_ser_ready,
  output logic tx_ir_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [BYTE_W:0] got[$]; // Taken bytes, top bit marks the infrared path
  // Idle byte lines show a changed value, so a stale byte cannot pass
  initial begin
    rx_ser_valid = 1'b0;
    rx_ir_valid = 1'b0;
    rx_ser_byte = 8'hC5;
    rx_ir_byte = 8'h3A;
  end
  assign tx_ser_ready = !stall;
  assign tx_ir_ready = !stall;
  // One-cycle byte pulse on the chosen receive path
  task automatic send(input logic [BYTE_W-1:0] b, input logic ir);
    @(posedge clk_sys);
    if (ir) begin
      rx_ir_valid <= 1'b1;
      rx_ir_byte <= b;
    end else begin
      rx_ser_valid <= 1'b1;
      rx_ser_byte <= b;
    end
    @(posedge clk_sys);
    rx_ser_valid <= 1'b0;
    rx_ir_valid <= 1'b0;
    rx_ser_byte <= ~b;
    rx_ir_byte <= ~b;
  endtask
  // A byte is taken at each edge where offer and ready meet
  always @(posedge clk_sys) begin
    if (tx_ser_valid_r && tx_ser_ready)
      got.push_back({1'b0, tx_data_r});
    if (tx_ir_valid_r && tx_ir_ready)
      got.push_back({1'b1, tx_data_r});
  end
endmodule

// File: test/uss_shadow_port_tb.sv
// Self-checking bench for the shadow receive/transmit data port
module uss_shadow_port_tb
  import uss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall = 1'b1; // Far end refuses bytes while high
  logic [DATA_W-1:0] rdata_r;
  logic rx_ser_valid, rx_ir_valid, tx_ser_ready, tx_ir_ready;
  logic [BYTE_W-1:0] rx_ser_byte, rx_ir_byte, tx_data_r;
  logic tx_ser_valid_r, tx_ir_valid_r, irq_r;
  logic [DATA_W-1:0] d; // Last read value
  int fail_count = 0;
  int compares = 0;
  initial forever #5 clk_sys = ~clk_sys;
  uss_shadow_port dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
    .rx_ser_valid(rx_ser_valid), .rx_ser_byte(rx_ser_byte),
    .rx_ir_valid(rx_ir_valid), .rx_ir_byte(rx_ir_byte),
    .tx_ser_ready(tx_ser_ready), .tx_ir_ready(tx_ir_ready),
    .tx_ser_valid_r(tx_ser_valid_r), .tx_ir_valid_r(tx_ir_valid_r),
    .tx_data_r(tx_data_r), .irq_r(irq_r));
  uss_far_end far (.clk_sys(clk_sys), .stall(stall),
    .tx_ser_valid_r(tx_ser_valid_r), .tx_ir_valid_r(tx_ir_valid_r),
    .tx_data_r(tx_data_r), .rx_ser_valid(rx_ser_valid),
    .rx_ser_byte(rx_ser_byte), .rx_ir_valid(rx_ir_valid),
    .rx_ir_byte(rx_ir_byte), .tx_ser_ready(tx_ser_ready),
    .tx_ir_ready(tx_ir_ready));
  // Compare one value, count it, report a difference
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is taken in the following cycle
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic summarize();
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(CTRL_ADDR); chk("ctrl", d, 32'h0000_0000);
    rd_reg(STAT_ADDR); chk("stat", d, 32'h0000_0020);
    rd_reg(ISTAT_ADDR); chk("istat", d, 32'h0000_0000);
    rd_reg(SHD_12_ADDR); chk("shd12 reset", d, 32'h0000_0000);
    rd_reg(SHD_BASE + 2); chk("unaligned", d, 32'h0000_0000);
    rd_reg(32'h5000_1090); chk("unmapped", d, 32'h0000_0000);
    // Every alias word pops the received byte, upper bits zero
    for (int i = 0; i < 16; i++) begin
      far.send(8'hE0 + i, 1'b0);
      rd_reg(STAT_ADDR); chk("ready", d[STAT_DR], 1'b1);
      rd_reg(SHD_BASE + 4 * i); chk("alias", d, 8'hE0 + i);
    end
    // Unread byte is overwritten and overrun flagged
    wr_reg(ISTAT_ADDR, 32'h0000_0007);
    far.send(8'h5A, 1'b0);
    far.send(8'hA5, 1'b0);
    rd_reg(SHD_13_ADDR); chk("overwrite", d, 32'h0000_00A5);
    rd_reg(ISTAT_ADDR); chk("ovr off", d[EV_OVR], 1'b1);
    // Receive FIFO fills, drops the extra byte, pops in order
    wr_reg(CTRL_ADDR, 32'h0000_0001);
    wr_reg(ISTAT_ADDR, 32'h0000_0007);
    for (int i = 0; i < 17; i++) far.send(8'h10 + i, 1'b0);
    rd_reg(STAT_ADDR); chk("rx full", d[STAT_RX_FULL], 1'b1);
    rd_reg(ISTAT_ADDR); chk("ovr on", d[EV_OVR], 1'b1);
    for (int i = 0; i < 16; i++) begin
      rd_reg(SHD_BASE + 4 * i); chk("rx head", d, 8'h10 + i);
    end
    rd_reg(STAT_ADDR); chk("rx drained", d[STAT_DR], 1'b0);
    // Infrared receive path
    wr_reg(CTRL_ADDR, 32'h0000_0003);
    far.send(8'h6C, 1'b1);
    rd_reg(SHD_BASE); chk("ir rx", d, 32'h0000_006C);
    // Infrared receive with FIFO off; a serial byte must be ignored
    wr_reg(CTRL_ADDR, 32'h0000_0002);
    far.send(8'h9D, 1'b1);
    far.send(8'h33, 1'b0);
    rd_reg(SHD_BASE + 8); chk("ir rx off", d, 32'h0000_009D);
    // Holding byte without FIFO: one write clears empty, next replaces
    wr_reg(CTRL_ADDR, 32'h0000_0000);
    far.got.delete();
    wr_reg(SHD_BASE, 32'h0000_00A1);
    repeat (3) @(posedge clk_sys);
    rd_reg(STAT_ADDR); chk("tx_holding_empty_flag set", d[STAT_TX_HOLDING_EMPTY_FLAG], 1'b1);
    rd_reg(ISTAT_ADDR); chk("tx_holding_empty_flag event", d[EV_TX_HOLDING_EMPTY_FLAG], 1'b1);
    wr_reg(SHD_12_ADDR, 32'h0000_00B2);
    rd_reg(STAT_ADDR); chk("tx_holding_empty_flag clr", d[STAT_TX_HOLDING_EMPTY_FLAG], 1'b0);
    wr_reg(SHD_LAST, 32'h1234_FFC3);
    stall <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("tx n", far.got.size(), 2);
    chk("tx a", far.got[0], 9'h0A1);
    chk("tx c", far.got[1], 9'h0C3);
    // Infrared transmit FIFO: seventeen held, eighteenth dropped
    stall <= 1'b1;
    wr_reg(CTRL_ADDR, 32'h0000_0003);
    far.got.delete();
    for (int i = 0; i < 18; i++) wr_reg(SHD_BASE + 4 * i[3:0], 8'h40 + i);
    rd_reg(STAT_ADDR); chk("tx full", d[STAT_TX_FULL], 1'b1);
    stall <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk("tx cnt", far.got.size(), 17);
    for (int i = 0; i < 17; i++) begin
      chk("tx ir", far.got[i], 9'h140 + i);
    end
    // Interrupt raised, masked and cleared
    wr_reg(CTRL_ADDR, 32'h0000_0000);
    wr_reg(IMASK_ADDR, 32'h0000_0001);
    wr_reg(ISTAT_ADDR, 32'h0000_0007);
    // Interrupt output is looked at off the edge, once it has settled
    repeat (3) @(posedge clk_sys);
    #1;
    chk("irq idle", irq_r, 1'b0);
    far.send(8'h77, 1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("irq on", irq_r, 1'b1);
    wr_reg(IMASK_ADDR, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("irq masked", irq_r, 1'b0);
    wr_reg(IMASK_ADDR, 32'h0000_0001);
    wr_reg(ISTAT_ADDR, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("irq cleared", irq_r, 1'b0);
    rd_reg(IMASK_ADDR); chk("imask", d, 32'h0000_0001);
    summarize();
  end
endmodule
